//--- i2c_target_register_port.sv
// device end: two-wire target giving access to clock and memory spaces
// What this block does
// - eight data bits then one acknowledge clock
// - acknowledge every byte received when addressed
// - controller acknowledges all read bytes but last
// - acknowledger holds data low through ack high
// - no-ack ends read; target releases data line
// - respond only to matching address after start
// - answer DE/DF clock space, AE/AF memory
// - address lsb one reads, zero writes
// - byte after write address loads the pointer
// - out-of-range pointer ignores transfer, still acks
// - store data bytes at pointer, then increment
// - pointer wraps to zero past space end
// - write sequence ends with stop or restart
// - read starts at current pointer position
// - shift read data at once, increment after
// - clock low past timeout returns to idle
// - data edges while clock high mark start/stop
// - ignore bus pins while on backup supply
`timescale 1ns/1ps
`include "i2c_port_defines.svh"
module i2c_target_register_port (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  i2c_bus_if.target bus,
  input wire logic on_backup_i,
  input wire logic [7:0] rd_data_i,
  output logic clk_sel_o,
  output logic mem_sel_o,
  output logic wr_en_o,
  output logic [7:0] addr_o,
  output logic [7:0] wr_data_o
);
  // ****************************************
  // pin synchronisers and line events
  // ****************************************
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic scl_d_r;
  logic sda_d_r;
  // first stage is read only by the second stage
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_sync_r <= 2'b11;
      sda_sync_r <= 2'b11;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], bus.scl};
      sda_sync_r <= {sda_sync_r[0], bus.sda};
      scl_d_r <= scl_sync_r[1];
      sda_d_r <= sda_sync_r[1];
    end
  end
  wire scl_s = scl_sync_r[1];
  wire sda_s = sda_sync_r[1];
  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_ev = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // ****************************************
  // stuck clock watchdog
  // ****************************************
  // counter saturates so a held-low clock keeps the port parked
  logic [20:0] low_cnt_r;
  wire [20:0] tmo_cyc = 21'(`BUS_STUCK_TIMEOUT_CYC);
  wire stuck = (low_cnt_r >= tmo_cyc);
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_cnt_r <= '0;
    end else if (scl_s) begin
      low_cnt_r <= '0;
    end else if (!stuck) begin
      low_cnt_r <= low_cnt_r + 21'd1;
    end
  end

  // ****************************************
  // byte engine
  // ****************************************
  i2c_port_pkg::tgt_state_t st_r, st_nxt;
  logic [2:0] bit_r;
  logic [7:0] shf_r;
  logic [7:0] clk_ptr_r;
  logic [7:0] mem_ptr_r;
  logic space_mem_r;
  logic got_ptr_r, armed_r;
  logic ignore_r;
  logic sda_low_r;
  logic clk_sel_r, mem_sel_r, wr_en_r;
  logic [7:0] addr_r, wr_data_r;

  wire abort = on_backup_i | stuck;
  wire addr_clk = ({shf_r[7:1], 1'b0} == `CLK_SPACE_WR_ADDR);
  wire addr_mem = ({shf_r[7:1], 1'b0} == `MEM_SPACE_WR_ADDR);
  wire addr_hit = addr_clk | addr_mem;
  wire [7:0] cur_ptr = space_mem_r ? mem_ptr_r : clk_ptr_r;
  wire [7:0] ptr_max = space_mem_r ? `MEM_PTR_MAX : `CLK_PTR_MAX;
  // pointer past the top of the space wraps to zero
  wire [7:0] ptr_inc = (cur_ptr >= ptr_max) ? `PTR_WRAP :
                       cur_ptr + 8'd1;
  wire ptr_bad = space_mem_r && (shf_r > `MEM_PTR_MAX);

  // next state on synchronised clock edges
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      i2c_port_pkg::TS_IDLE: st_nxt = st_r;
      i2c_port_pkg::TS_ADDR: begin
        if (scl_fall && armed_r && bit_r == 3'd0)
          st_nxt = addr_hit ? i2c_port_pkg::TS_ADDR_ACK :
                   i2c_port_pkg::TS_IDLE;
      end
      i2c_port_pkg::TS_ADDR_ACK: begin
        if (scl_fall)
          st_nxt = shf_r[0] ? i2c_port_pkg::TS_TX :
                   i2c_port_pkg::TS_RX;
      end
      i2c_port_pkg::TS_RX: begin
        if (scl_fall && bit_r == 3'd0)
          st_nxt = i2c_port_pkg::TS_RX_ACK;
      end
      i2c_port_pkg::TS_RX_ACK: begin
        if (scl_fall)
          st_nxt = i2c_port_pkg::TS_RX;
      end
      i2c_port_pkg::TS_TX: begin
        if (scl_fall && bit_r == 3'd0)
          st_nxt = i2c_port_pkg::TS_TX_ACK;
      end
      i2c_port_pkg::TS_TX_ACK: begin
        if (scl_rise && sda_s)
          st_nxt = i2c_port_pkg::TS_IDLE;
        else if (scl_fall)
          st_nxt = i2c_port_pkg::TS_TX;
      end
      default: st_nxt = i2c_port_pkg::TS_IDLE;
    endcase
    if (stop_ev)
      st_nxt = i2c_port_pkg::TS_IDLE;
    if (start_ev)
      st_nxt = i2c_port_pkg::TS_ADDR;
    if (abort)
      st_nxt = i2c_port_pkg::TS_IDLE;
  end

  wire entering_tx = (st_nxt == i2c_port_pkg::TS_TX) &&
                     (st_r != i2c_port_pkg::TS_TX);
  wire rx_done = (st_r == i2c_port_pkg::TS_RX) && scl_fall && bit_r == 3'd0;
  wire tx_done = (st_r == i2c_port_pkg::TS_TX) && scl_fall && bit_r == 3'd0;
  wire store = rx_done && got_ptr_r && !ignore_r;
  wire addr_armed = (st_r == i2c_port_pkg::TS_ADDR) && armed_r;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= i2c_port_pkg::TS_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // the clock fall right after a start carries no bit, so the address
  // count only runs once the first address bit has been clocked in
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_r <= 1'b0;
    end else if (start_ev) begin
      armed_r <= 1'b0;
    end else if (scl_rise && st_r == i2c_port_pkg::TS_ADDR) begin
      armed_r <= 1'b1;
    end
  end

  // shift register and bit counter
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shf_r <= '0;
      bit_r <= 3'd7;
    end else if (start_ev || st_nxt == i2c_port_pkg::TS_RX_ACK ||
                 st_nxt == i2c_port_pkg::TS_ADDR_ACK) begin
      bit_r <= 3'd7;
    end else if (entering_tx) begin
      shf_r <= rd_data_i;
      bit_r <= 3'd7;
    end else if (scl_rise && (st_r == i2c_port_pkg::TS_ADDR ||
                              st_r == i2c_port_pkg::TS_RX)) begin
      shf_r <= {shf_r[6:0], sda_s};
    end else if (scl_fall && (addr_armed ||
                              st_r == i2c_port_pkg::TS_RX ||
                              st_r == i2c_port_pkg::TS_TX)) begin
      bit_r <= bit_r - 3'd1;
      if (st_r == i2c_port_pkg::TS_TX)
        shf_r <= {shf_r[6:0], 1'b1};
    end
  end

  // pointer, space and ignore bookkeeping
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_ptr_r <= '0;
      mem_ptr_r <= '0;
      space_mem_r <= 1'b0;
      got_ptr_r <= 1'b0;
      ignore_r <= 1'b0;
    end else begin
      if (st_r == i2c_port_pkg::TS_ADDR && st_nxt ==
          i2c_port_pkg::TS_ADDR_ACK) begin
        space_mem_r <= addr_mem;
        got_ptr_r <= 1'b0;
        ignore_r <= 1'b0;
      end
      if (rx_done && !got_ptr_r) begin
        got_ptr_r <= 1'b1;
        ignore_r <= ptr_bad;
        if (!ptr_bad && space_mem_r)
          mem_ptr_r <= shf_r;
        else if (!ptr_bad)
          clk_ptr_r <= shf_r;
      end
      if (store || tx_done) begin
        if (space_mem_r)
          mem_ptr_r <= ptr_inc;
        else
          clk_ptr_r <= ptr_inc;
      end
    end
  end

  // data line drive: ack low in ack slots, else transmit bits
  wire drive_ack = (st_nxt == i2c_port_pkg::TS_ADDR_ACK) ||
                   (st_nxt == i2c_port_pkg::TS_RX_ACK);
  wire drive_tx = (st_nxt == i2c_port_pkg::TS_TX) &&
                  !(entering_tx ? rd_data_i[7] : shf_r[7]);
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sda_low_r <= 1'b0;
    end else if (scl_fall || scl_s == 1'b0 || abort || start_ev) begin
      sda_low_r <= !abort && (drive_ack || drive_tx);
    end
  end

  // storage port, registered
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_sel_r <= 1'b0;
      mem_sel_r <= 1'b0;
      wr_en_r <= 1'b0;
      addr_r <= '0;
      wr_data_r <= '0;
    end else begin
      clk_sel_r <= ~space_mem_r;
      mem_sel_r <= space_mem_r;
      wr_en_r <= store;
      addr_r <= (store || tx_done) ? cur_ptr :
                (rx_done && !got_ptr_r && !ptr_bad) ? shf_r :
                (store ? cur_ptr : (tx_done ? ptr_inc : cur_ptr));
      wr_data_r <= store ? shf_r : wr_data_r;
    end
  end

  assign clk_sel_o = clk_sel_r;
  assign mem_sel_o = mem_sel_r;
  assign wr_en_o = wr_en_r;
  assign addr_o = addr_r;
  assign wr_data_o = wr_data_r;
  assign bus.sda_o_tgt = 1'b0;
  assign bus.sda_oe_tgt = sda_low_r;
endmodule

//--- i2c_port_defines.svh
// constants for the two-wire register port
`ifndef I2C_PORT_DEFINES_SVH
`define I2C_PORT_DEFINES_SVH
`define CLK_HZ 40000000
`define CLK_SPACE_WR_ADDR 8'hDE
`define CLK_SPACE_RD_ADDR 8'hDF
`define MEM_SPACE_WR_ADDR 8'hAE
`define MEM_SPACE_RD_ADDR 8'hAF
`define MEM_PTR_MAX 8'h7F
`define CLK_PTR_MAX 8'hFF
`define PTR_WRAP 8'h00
`define BUS_STUCK_TIMEOUT_MS 25
`define BUS_STUCK_TIMEOUT_CYC ((`BUS_STUCK_TIMEOUT_MS * (`CLK_HZ / 1000)) + 1)
`define SCL_HALF_NS 1250
`define SCL_HALF_CYC ((`SCL_HALF_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`endif

//--- i2c_port_pkg.sv
// types shared by both ends of the two-wire register port
package i2c_port_pkg;
  typedef enum logic [2:0] {
    TS_IDLE = 3'b000,
    TS_ADDR = 3'b001,
    TS_ADDR_ACK = 3'b010,
    TS_RX = 3'b011,
    TS_RX_ACK = 3'b100,
    TS_TX = 3'b101,
    TS_TX_ACK = 3'b110
  } tgt_state_t;
  typedef enum logic [3:0] {
    CS_IDLE = 4'b0000,
    CS_START = 4'b0001,
    CS_BIT_LO = 4'b0010,
    CS_BIT_HI = 4'b0011,
    CS_ACK_LO = 4'b0100,
    CS_ACK_HI = 4'b0101,
    CS_STOP_LO = 4'b0110,
    CS_STOP_HI = 4'b0111,
    CS_STOP_END = 4'b1000
  } ctl_state_t;
endpackage

//--- i2c_bus_if.sv
// two-wire bus carrier with wired-and resolution of both lines
`timescale 1ns/1ps
interface i2c_bus_if;
  logic scl_o_ctl;
  logic scl_oe_ctl;
  logic sda_o_ctl;
  logic sda_oe_ctl;
  logic sda_o_tgt;
  logic sda_oe_tgt;
  logic scl;
  logic sda;
  // open drain with pull-ups: any enabled driver pulls its line low
  assign scl = ~(scl_oe_ctl & ~scl_o_ctl);
  assign sda = ~((sda_oe_ctl & ~sda_o_ctl) | (sda_oe_tgt & ~sda_o_tgt));
  modport target (
    input scl,
    input sda,
    output sda_o_tgt,
    output sda_oe_tgt
  );
  modport controller (
    input scl,
    input sda,
    output scl_o_ctl,
    output scl_oe_ctl,
    output sda_o_ctl,
    output sda_oe_ctl
  );
endinterface

//--- i2c_bus_controller.sv
// far end: simple two-wire controller issuing single-byte steps
`timescale 1ns/1ps
`include "i2c_port_defines.svh"
module i2c_bus_controller (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  i2c_bus_if.controller bus,
  input wire logic cmd_valid_i,
  input wire logic cmd_start_i,
  input wire logic cmd_stop_i,
  input wire logic cmd_read_i,
  input wire logic cmd_last_i,
  input wire logic [7:0] cmd_data_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic ack_o,
  output logic [7:0] rd_data_o
);
  // ****************************************
  // bit sequencer
  // ****************************************
  i2c_port_pkg::ctl_state_t st_r;
  logic [7:0] half_r;
  logic [2:0] bit_r;
  logic [7:0] shf_r;
  logic rd_r, last_r, stop_r;
  logic scl_r, sda_r;
  logic done_r, ack_r;
  logic [7:0] rdd_r;
  logic [1:0] sda_sync_r;
  wire [7:0] half_cyc = 8'(`SCL_HALF_CYC);
  wire tick = (half_r == 8'd0);
  wire mid = (half_r == (half_cyc >> 1));
  wire sda_in = sda_sync_r[1];
  wire idle = (st_r == i2c_port_pkg::CS_IDLE);

  // data line back from the bus passes two flops
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sda_sync_r <= 2'b11;
      half_r <= '0;
    end else begin
      sda_sync_r <= {sda_sync_r[0], bus.sda};
      half_r <= (tick || idle) ? half_cyc : half_r - 8'd1;
    end
  end

  // one state per half clock period, except CS_START, which takes two (three on a restart)
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= i2c_port_pkg::CS_IDLE;
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      bit_r <= 3'd7;
      shf_r <= '0;
      rd_r <= 1'b0;
      last_r <= 1'b0;
      stop_r <= 1'b0;
      done_r <= 1'b0;
      ack_r <= 1'b0;
      rdd_r <= '0;
    end else begin
      done_r <= 1'b0;
      case (st_r)
        i2c_port_pkg::CS_IDLE: begin
          if (cmd_valid_i) begin
            shf_r <= cmd_data_i;
            rd_r <= cmd_read_i;
            last_r <= cmd_last_i;
            stop_r <= cmd_stop_i;
            bit_r <= 3'd7;
            if (cmd_start_i) begin
              sda_r <= 1'b1;
              st_r <= i2c_port_pkg::CS_START;
            end else begin
              st_r <= i2c_port_pkg::CS_BIT_LO;
            end
          end
        end
        i2c_port_pkg::CS_START: if (tick) begin
          if (scl_r && sda_r) begin
            sda_r <= 1'b0;
          end else if (!scl_r) begin
            scl_r <= 1'b1; // restart: raise clock first
          end else begin
            scl_r <= 1'b0;
            st_r <= i2c_port_pkg::CS_BIT_LO;
          end
        end
        i2c_port_pkg::CS_BIT_LO: begin
          // data moves mid-way through the low half, clear of both edges
          if (mid)
            sda_r <= rd_r ? 1'b1 : shf_r[7];
          if (tick) begin
            scl_r <= 1'b1;
            st_r <= i2c_port_pkg::CS_BIT_HI;
          end
        end
        i2c_port_pkg::CS_BIT_HI: if (tick) begin
          scl_r <= 1'b0;
          shf_r <= {shf_r[6:0], sda_in};
          if (bit_r == 3'd0) begin
            st_r <= i2c_port_pkg::CS_ACK_LO;
          end else begin
            bit_r <= bit_r - 3'd1;
            st_r <= i2c_port_pkg::CS_BIT_LO;
          end
        end
        i2c_port_pkg::CS_ACK_LO: begin
          // controller acks all read bytes but the last
          if (mid)
            sda_r <= rd_r ? last_r : 1'b1;
          if (tick) begin
            scl_r <= 1'b1;
            st_r <= i2c_port_pkg::CS_ACK_HI;
          end
        end
        i2c_port_pkg::CS_ACK_HI: if (tick) begin
          ack_r <= ~sda_in;
          rdd_r <= shf_r;
          scl_r <= 1'b0;
          done_r <= ~stop_r;
          st_r <= stop_r ? i2c_port_pkg::CS_STOP_LO :
                  i2c_port_pkg::CS_IDLE;
        end
        i2c_port_pkg::CS_STOP_LO: if (tick) begin
          sda_r <= 1'b0;
          st_r <= i2c_port_pkg::CS_STOP_HI;
        end
        i2c_port_pkg::CS_STOP_HI: if (tick) begin
          scl_r <= 1'b1;
          st_r <= i2c_port_pkg::CS_STOP_END;
        end
        i2c_port_pkg::CS_STOP_END: if (tick) begin
          sda_r <= 1'b1;
          done_r <= 1'b1;
          st_r <= i2c_port_pkg::CS_IDLE;
        end
        default: st_r <= i2c_port_pkg::CS_IDLE;
      endcase
    end
  end

  assign cmd_ready_o = idle;
  assign done_o = done_r;
  assign ack_o = ack_r;
  assign rd_data_o = rdd_r;
  assign bus.scl_o_ctl = 1'b0;
  assign bus.scl_oe_ctl = ~scl_r;
  assign bus.sda_o_ctl = 1'b0;
  assign bus.sda_oe_ctl = ~sda_r;
endmodule

//--- i2c_port_sva.sv
// bus checker watching the lines between controller and target
`timescale 1ns/1ps
`include "i2c_port_defines.svh"
module i2c_port_sva (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic on_backup_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_oe_tgt
);
  logic scl_q, sda_q, first_r, addr_ok_r, rd_dir_r, nack_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  // **********************************************************
  // frame tracking
  // **********************************************************
  // start and stop are data edges seen while the clock stays high
  wire bus_start = scl & scl_q & sda_q & ~sda;
  wire bus_stop = scl & scl_q & ~sda_q & sda;
  wire scl_rise = scl & ~scl_q;
  wire ack_rise = scl_rise & (cnt_r == 4'h8);
  wire hit = ~on_backup_i & ((sh_r == `CLK_SPACE_WR_ADDR) |
    (sh_r == `CLK_SPACE_RD_ADDR) | (sh_r == `MEM_SPACE_WR_ADDR) |
    (sh_r == `MEM_SPACE_RD_ADDR));
  // bit count restarts at each start so a restart realigns bytes
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {scl_q, sda_q, first_r, addr_ok_r, rd_dir_r, nack_r} <= 6'h30;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (bus_start) begin
        {first_r, addr_ok_r, nack_r} <= 3'h4;
        cnt_r <= 4'h0;
      end else if (bus_stop) begin
        addr_ok_r <= 1'b0;
      end else if (ack_rise) begin
        cnt_r <= 4'h0;
        first_r <= 1'b0;
        if (first_r) begin
          addr_ok_r <= hit;
          rd_dir_r <= sh_r[0];
        end
        if (!first_r & addr_ok_r & rd_dir_r & sda) begin
          nack_r <= 1'b1;
        end
      end else if (scl_rise) begin
        cnt_r <= cnt_r + 4'h1;
        sh_r <= {sh_r[6:0], sda};
      end
    end
  end
  // **********************************************************
  // properties
  // **********************************************************
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  property p_addr_ack;
    ack_rise && first_r |-> sda == !hit;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("address ack does not match decode");
  property p_addr_quiet;
    first_r && cnt_r < 4'h8 |-> !sda_oe_tgt;
  endproperty
  a_addr_quiet: assert property (p_addr_quiet)
    else $error("target drives during address bits");
  property p_wr_ack;
    ack_rise && !first_r && addr_ok_r && !rd_dir_r |-> !sda;
  endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("received byte not acknowledged");
  property p_nack_release;
    nack_r |-> !sda_oe_tgt;
  endproperty
  a_nack_release: assert property (p_nack_release)
    else $error("target holds data line after not-ack");
  property p_stray;
    !first_r && !addr_ok_r |-> !sda_oe_tgt;
  endproperty
  a_stray: assert property (p_stray)
    else $error("unaddressed target drives data line");
  property p_oe_steady;
    scl && scl_q |-> $stable(sda_oe_tgt);
  endproperty
  a_oe_steady: assert property (p_oe_steady)
    else $error("target data changes while clock high");
  property p_whole_bytes;
    bus_stop |-> cnt_r == 4'h1;
  endproperty
  a_whole_bytes: assert property (p_whole_bytes)
    else $error("stop inside a byte");
  property p_ack_slot;
    ack_rise |-> ##[1:120] !scl;
  endproperty
  a_ack_slot: assert property (p_ack_slot)
    else $error("ack clock pulse too long");
  property p_start_clock;
    bus_start |-> ##[1:120] !scl;
  endproperty
  a_start_clock: assert property (p_start_clock)
    else $error("clock not pulled low after start");
endmodule

//--- tb.sv
// self-checking bench joining controller and target over the bus
`timescale 1ns/1ps
`include "i2c_port_defines.svh"
`define CHECK_EQ(g, e) begin n_checks++; if ((g) !== (e)) begin \
  fail_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
  logic ref_clk_i, rst_i, on_backup_i, cmd_valid_i, cmd_start_i;
  logic cmd_stop_i, cmd_read_i, cmd_last_i, clk_sel_o, mem_sel_o;
  logic wr_en_o, cmd_ready_o, done_o, ack_o;
  logic [7:0] cmd_data_i, rd_data_i, addr_o, wr_data_o, rd_data_o, p, wa;
  logic [7:0] stor [2][256];
  logic [7:0] mdl [2][256];
  logic [17:0] exp_q [$];
  logic [17:0] e;
  logic [31:0] seed;
  int ptr_m [2];
  int fail_count, n_checks, cyc;
  i2c_bus_if bus_if();
  i2c_target_register_port i_i2c_target_register_port (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus(bus_if),
    .on_backup_i(on_backup_i), .rd_data_i(rd_data_i),
    .clk_sel_o(clk_sel_o), .mem_sel_o(mem_sel_o), .wr_en_o(wr_en_o),
    .addr_o(addr_o), .wr_data_o(wr_data_o));
  i2c_bus_controller i_i2c_bus_controller (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus(bus_if),
    .cmd_valid_i(cmd_valid_i), .cmd_start_i(cmd_start_i),
    .cmd_stop_i(cmd_stop_i), .cmd_read_i(cmd_read_i),
    .cmd_last_i(cmd_last_i), .cmd_data_i(cmd_data_i),
    .cmd_ready_o(cmd_ready_o), .done_o(done_o), .ack_o(ack_o),
    .rd_data_o(rd_data_o));
  i2c_port_sva u_sva (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .on_backup_i(on_backup_i),
    .scl(bus_if.scl), .sda(bus_if.sda), .sda_oe_tgt(bus_if.sda_oe_tgt));
  // **********************************************************
  // storage stand-in and helpers
  // **********************************************************
  // reads stay combinational since the target samples them at once
  assign rd_data_i = clk_sel_o ? stor[0][addr_o] :
    stor[1][{1'b0, addr_o[6:0]}];
  // every write pulse must match the next expected store
  always @(negedge ref_clk_i) begin
    if (rst_i === 1'b0 && wr_en_o === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 18'h0_0000;
      `CHECK_EQ({clk_sel_o, mem_sel_o, addr_o, wr_data_o}, e)
      stor[mem_sel_o][mem_sel_o ? {1'b0, addr_o[6:0]} : addr_o] = wr_data_o;
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic complete_run();
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one controller step: valid held until taken, then wait for done
  task automatic step(input logic s, q, r, l, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    {cmd_valid_i, cmd_start_i, cmd_stop_i, cmd_read_i} = {1'b1, s, q, r};
    cmd_last_i = l;
    cmd_data_i = d;
    while (cmd_ready_o !== 1'b1) @(negedge ref_clk_i);
    @(negedge ref_clk_i);
    cmd_valid_i = 1'b0;
    while (done_o !== 1'b1 && n < 4000) begin
      @(negedge ref_clk_i);
      n++;
    end
    `CHECK_EQ(done_o, 1'b1)
  endtask
  // the model only moves when the target is live and the pointer valid
  task automatic wr_seq(input int sp, input logic [7:0] adr,
                        input bit live, input logic [7:0] ptr, input int n);
    logic [7:0] d;
    bit ok;
    ok = live && (sp == 0 || ptr <= `MEM_PTR_MAX);
    step(1'b1, 1'b0, 1'b0, 1'b0, adr);
    `CHECK_EQ(ack_o, live)
    // a pointer-only write is closed by the next sequence's restart
    step(1'b0, 1'b0, 1'b0, 1'b0, ptr);
    `CHECK_EQ(ack_o, live)
    if (ok) ptr_m[sp] = ptr;
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      d = seed[7:0];
      if (ok) begin
        exp_q.push_back({sp == 0, sp == 1, ptr_m[sp][7:0], d});
        mdl[sp][ptr_m[sp]] = d;
        ptr_m[sp] = (ptr_m[sp] + 1) % (sp ? 128 : 256);
      end
      step(1'b0, i == n - 1, 1'b0, 1'b0, d);
      `CHECK_EQ(ack_o, live)
    end
  endtask
  task automatic rd_seq(input int sp, input int n);
    step(1'b1, 1'b0, 1'b0, 1'b0,
         sp ? `MEM_SPACE_RD_ADDR : `CLK_SPACE_RD_ADDR);
    `CHECK_EQ(ack_o, 1'b1)
    for (int i = 0; i < n; i++) begin
      step(1'b0, i == n - 1, 1'b1, i == n - 1, 8'h00);
      `CHECK_EQ(rd_data_o, mdl[sp][ptr_m[sp]])
      `CHECK_EQ(ack_o, i != n - 1)
      ptr_m[sp] = (ptr_m[sp] + 1) % (sp ? 128 : 256);
    end
  endtask
  // **********************************************************
  // clock, watchdog and scenarios
  // **********************************************************
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  // a hung handshake ends the run as a failure
  initial begin
    cyc = 0;
    forever begin
      @(posedge ref_clk_i);
      cyc++;
      if (cyc == 90000) begin
        fail_count++;
        complete_run();
      end
    end
  end
  initial begin
    {rst_i, on_backup_i, cmd_valid_i, cmd_start_i} = 4'h8;
    {cmd_stop_i, cmd_read_i, cmd_last_i} = 3'h0;
    cmd_data_i = 8'h00;
    seed = 32'h0000_e11b;
    for (int i = 0; i < 256; i++) begin
      seed = lfsr(seed);
      {stor[0][i], stor[1][i]} = seed[15:0];
      {mdl[0][i], mdl[1][i]} = seed[15:0];
    end
    repeat (6) @(negedge ref_clk_i);
    rst_i = 1'b0;
    // wrap writes and reads, pointer-only set, then a random burst
    for (int sp = 0; sp < 2; sp++) begin
      wa = sp ? `MEM_SPACE_WR_ADDR : `CLK_SPACE_WR_ADDR;
      p = sp ? `MEM_PTR_MAX - 8'h01 : `CLK_PTR_MAX - 8'h01;
      wr_seq(sp, wa, 1'b1, p, 3);
      wr_seq(sp, wa, 1'b1, p, 0);
      rd_seq(sp, 3);
      wr_seq(sp, wa, 1'b1, seed[15:8] >> sp, 2);
      rd_seq(sp, 1);
    end
    // out-of-range memory pointer leaves pointer and contents alone
    wr_seq(1, `MEM_SPACE_WR_ADDR, 1'b1, 8'h80 | seed[7:0], 2);
    rd_seq(1, 1);
    wr_seq(0, 8'hA0, 1'b0, 8'h11, 1);
    @(negedge ref_clk_i);
    on_backup_i = 1'b1;
    wr_seq(0, `CLK_SPACE_WR_ADDR, 1'b0, 8'h05, 1);
    on_backup_i = 1'b0;
    rd_seq(0, 1);
    `CHECK_EQ(exp_q.size(), 0)
    complete_run();
  end
endmodule
